// >>> ssl_pkg.sv
// Shared constants and types of the speed loop front end.
// Assumes a single 250 MHz clock and AHB-Lite register access.
package ssl_pkg;

	// Register byte addresses (low 12 address bits decoded)
	localparam logic [11:0] ADDR_MAX_SPEED = 12'h150;
	localparam logic [11:0] ADDR_KP = 12'h208;
	localparam logic [11:0] ADDR_KI = 12'h20c;
	localparam logic [11:0] ADDR_KF = 12'h210;
	localparam logic [11:0] ADDR_TUNE = 12'h240;
	localparam logic [11:0] ADDR_INERTIA = 12'h300;
	localparam logic [11:0] ADDR_BW = 12'h304;
	localparam logic [11:0] ADDR_STATUS = 12'h308;
	localparam logic [11:0] ADDR_PRESET0 = 12'h310;
	localparam logic [11:0] ADDR_PRESET1 = 12'h314;
	localparam logic [11:0] ADDR_PRESET2 = 12'h318;
	localparam logic [11:0] ADDR_SPEED_RD = 12'h320;

	// Status register field positions
	localparam int STAT_STABLE_BIT = 32'h0;
	localparam int STAT_EST_EN_BIT = 32'h1;

	// Upper bounds of writable values
	localparam logic [15:0] MAX_SPEED_MAX = 16'h2710;
	localparam logic [15:0] KP_MAX = 16'h1fff;
	localparam logic [15:0] KI_MAX = 16'h03ff;
	localparam logic [15:0] KF_MAX = 16'h0064;
	localparam logic [15:0] TUNE_MAX = 16'h0002;
	localparam logic [15:0] BW_MAX = 16'h0009;

	// Reset values
	localparam logic [15:0] MAX_SPEED_RST = 16'h0bb8;
	localparam logic [15:0] KP_RST = 16'h01f4;
	localparam logic [15:0] KI_RST = 16'h0000;
	localparam logic [15:0] KF_RST = 16'h0000;
	localparam logic [15:0] INERTIA_RST = 16'h000a;
	localparam logic [15:0] BW_RST = 16'h0004;

	// Analog scaling: reference arrives in millivolts, full scale 10 V
	localparam int FULL_SCALE_V = 32'ha;
	localparam int MV_PER_V = 32'h3e8;
	localparam logic signed [32:0] SCALE_DIV = 33'(FULL_SCALE_V * MV_PER_V);
	localparam logic signed [15:0] FULL_SCALE_MV = 16'(FULL_SCALE_V * MV_PER_V);

	// Automatic gain derivation
	localparam logic [15:0] KP_PER_LEVEL = 16'h0032;
	localparam logic [15:0] INERTIA_UNIT = 16'h000a;
	localparam logic [15:0] INERTIA_HIGH = 16'h00c8;

	// Periodic inertia save
	localparam longint SAVE_PERIOD_MIN = 64'h1e;
	localparam longint SEC_PER_MIN = 64'h3c;
	localparam longint CLK_HZ = 64'hee6b280;
	localparam logic [39:0] SAVE_PERIOD_CYCLES = 40'(SAVE_PERIOD_MIN * SEC_PER_MIN * CLK_HZ);

	typedef enum logic [1:0] {TUNE_MANUAL, TUNE_AUTO, TUNE_SEMI} ssl_tuning_e;

	typedef struct packed {
		logic signed [15:0] scaled;
	} ssl_scaler_s;

endpackage : ssl_pkg

// >>> ssl_scale_if.sv
// Carries the analog reference and range to the scaler and the result back.
// Assumes both ends run on the same clock.
interface ssl_scale_if;
	logic signed [15:0] ref_mv;
	logic [15:0] max_speed;
	logic signed [15:0] scaled;
	modport scaler (input ref_mv, input max_speed, output scaled);
	modport user (output ref_mv, output max_speed, input scaled);
endinterface : ssl_scale_if

// >>> ssl_scaler.sv
// Scales a millivolt reference by the full-scale speed setting.
// Assumes inputs already synchronous to hclk; result lags by one cycle.
module ssl_scaler (
	input wire logic hclk,
	input wire logic hresetn,
	ssl_scale_if.scaler sif
);
	ssl_pkg::ssl_scaler_s st_ff;
	ssl_pkg::ssl_scaler_s nxt_st;
	logic signed [32:0] prod;
	logic signed [32:0] quo;

	// Speed = volts x setting / 10, in millivolts
	always_comb begin
		prod = 33'(sif.ref_mv) * 33'($signed({1'b0, sif.max_speed}));
		quo = prod / ssl_pkg::SCALE_DIV;
		nxt_st.scaled = quo[15:0];
	end

	// Result register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sif.scaled = st_ff.scaled;

	property p_scale;
		@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> sif.scaled == 16'((33'($past(sif.ref_mv)) * 33'($signed({1'b0, $past(sif.max_speed)})))
			/ ssl_pkg::SCALE_DIV);
	endproperty
	a_scale: assert property (p_scale) else $error("scaled speed wrong");

	property p_full_scale;
		@(posedge hclk) disable iff (!hresetn)
		(sif.ref_mv == ssl_pkg::FULL_SCALE_MV) |=> sif.scaled == $signed($past(sif.max_speed));
	endproperty
	a_full_scale: assert property (p_full_scale) else $error("full scale not max speed");

endmodule : ssl_scaler

// >>> ssl_speed_loop.sv
// Speed control front end: analog scaling, command select, speed gains, tuning.
// Assumes AHB-Lite master on hclk; pins and estimator outputs are asynchronous.
// Function
// - Command equals volts times max speed over ten
// - Max speed maps to 10 V, both modes
// - Select inputs choose command only when servo on
// - Tuning selector holds 0 to 2
// - Manual uses user gains, automatic functions off
// - Leaving automatic for manual loads measured gains
// - Auto mode estimates, saves inertia every 30 minutes
// - Ten bandwidth levels, gains from measured inertia
// - Semi-auto: stable sets status, stops, saves inertia
// - Excessive inertia clears status, resumes estimation
// - Proportional gain 0..8191, default 500
// - Integral gain 0..1023
// - Feed-forward gain 0..100 percent, default 0
module ssl_speed_loop #(
	parameter logic [39:0] SAVE_CYCLES = ssl_pkg::SAVE_PERIOD_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic servo_on,
	input wire logic [1:0] speed_select_inputs,
	input wire logic zero_reference_speed_mode,
	input wire logic torque_mode,
	input wire logic [15:0] ref_mv,
	input wire logic [15:0] est_inertia,
	input wire logic inertia_settled,
	output logic [15:0] speed_cmd,
	output logic [15:0] speed_limit,
	output logic [15:0] proportional_gain,
	output logic [15:0] integral_gain,
	output logic [15:0] feedforward_gain,
	output logic est_enable,
	output logic inertia_stable_status
);
	typedef struct packed {
		logic [37:0] sync1;
		logic [37:0] sync2;
		logic wr_pend;
		logic rd_wait;
		logic [11:0] addr;
		logic [31:0] hrdata;
		logic [15:0] max_speed;
		logic [15:0] kp;
		logic [15:0] ki;
		logic [15:0] kf;
		ssl_pkg::ssl_tuning_e mode;
		logic [15:0] inertia;
		logic [15:0] bw;
		logic [2:0][15:0] preset;
		logic stable;
		logic [39:0] save_cnt;
		logic [15:0] auto_kp;
		logic [15:0] auto_ki;
		logic [15:0] speed_cmd;
		logic [15:0] speed_limit;
		logic [15:0] act_kp;
		logic [15:0] act_ki;
		logic [15:0] act_kf;
		logic est_en;
	} ssl_top_s;

	ssl_top_s st_ff;
	ssl_top_s nxt_st;
	ssl_scale_if sif ();

	logic s_servo_on;
	logic [1:0] s_sel;
	logic s_zref;
	logic s_torque;
	logic s_settled;
	logic [15:0] s_est;
	logic [15:0] s_ref;
	logic bus_take;
	logic [15:0] wv;
	logic [31:0] rd_val;
	logic [31:0] kp_calc;
	logic [31:0] ki_calc;
	logic est_high;
	logic save_due;

	// Synchronised pin view, second stage only
	assign {s_servo_on, s_sel, s_zref, s_torque, s_settled, s_est, s_ref} = st_ff.sync2;
	assign bus_take = hsel && hready && htrans[1];
	assign wv = hwdata[15:0];
	assign est_high = s_est > ssl_pkg::INERTIA_HIGH;
	assign save_due = st_ff.save_cnt >= SAVE_CYCLES - 40'h1;

	// Analog scaling
	assign sif.ref_mv = $signed(s_ref);
	assign sif.max_speed = st_ff.max_speed;
	ssl_scaler u_scaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.sif(sif)
	);

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
		clamp16 = (v > lim) ? lim : v;
	endfunction : clamp16

	// Gains from bandwidth level and stored inertia
	always_comb begin
		kp_calc = 32'(ssl_pkg::KP_PER_LEVEL * (st_ff.bw + 16'h1));
		kp_calc = (kp_calc * (32'(ssl_pkg::INERTIA_UNIT) + 32'(st_ff.inertia))) / 32'(ssl_pkg::INERTIA_UNIT);
		if (kp_calc > 32'(ssl_pkg::KP_MAX)) begin
			kp_calc = 32'(ssl_pkg::KP_MAX);
		end
		ki_calc = kp_calc >> 2;
		if (ki_calc > 32'(ssl_pkg::KI_MAX)) begin
			ki_calc = 32'(ssl_pkg::KI_MAX);
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		rd_val = 32'h0;
		case (st_ff.addr)
			ssl_pkg::ADDR_MAX_SPEED: rd_val = {16'h0, st_ff.max_speed};
			ssl_pkg::ADDR_KP: rd_val = {16'h0, st_ff.kp};
			ssl_pkg::ADDR_KI: rd_val = {16'h0, st_ff.ki};
			ssl_pkg::ADDR_KF: rd_val = {16'h0, st_ff.kf};
			ssl_pkg::ADDR_TUNE: rd_val = {30'h0, st_ff.mode};
			ssl_pkg::ADDR_INERTIA: rd_val = {16'h0, st_ff.inertia};
			ssl_pkg::ADDR_BW: rd_val = {16'h0, st_ff.bw};
			ssl_pkg::ADDR_STATUS: begin
				rd_val[ssl_pkg::STAT_STABLE_BIT] = st_ff.stable;
				rd_val[ssl_pkg::STAT_EST_EN_BIT] = st_ff.est_en;
			end
			ssl_pkg::ADDR_PRESET0: rd_val = {16'h0, st_ff.preset[0]};
			ssl_pkg::ADDR_PRESET1: rd_val = {16'h0, st_ff.preset[1]};
			ssl_pkg::ADDR_PRESET2: rd_val = {16'h0, st_ff.preset[2]};
			ssl_pkg::ADDR_SPEED_RD: rd_val = {16'h0, st_ff.speed_cmd};
			default: rd_val = 32'h0;
		endcase
	end

	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = {servo_on, speed_select_inputs, zero_reference_speed_mode, torque_mode,
			inertia_settled, est_inertia, ref_mv};
		nxt_st.sync2 = st_ff.sync1;
		// Bus address phase; reads take one wait cycle
		nxt_st.wr_pend = 1'b0;
		nxt_st.rd_wait = 1'b0;
		if (bus_take) begin
			nxt_st.addr = haddr[11:0];
			nxt_st.wr_pend = hwrite;
			nxt_st.rd_wait = !hwrite;
		end
		if (st_ff.rd_wait) begin
			nxt_st.hrdata = rd_val;
		end
		nxt_st.auto_kp = kp_calc[15:0];
		nxt_st.auto_ki = ki_calc[15:0];
		// Periodic save in continuous auto mode
		nxt_st.save_cnt = 40'h0;
		if (st_ff.mode == ssl_pkg::TUNE_AUTO) begin
			if (save_due) begin
				nxt_st.inertia = s_est;
			end else begin
				nxt_st.save_cnt = st_ff.save_cnt + 40'h1;
			end
		end
		// Semi-auto settling and excessive inertia
		if (st_ff.mode == ssl_pkg::TUNE_SEMI && !st_ff.stable && s_settled && !est_high) begin
			nxt_st.stable = 1'b1;
			nxt_st.inertia = s_est;
		end
		if (st_ff.mode != ssl_pkg::TUNE_MANUAL && est_high) begin
			nxt_st.stable = 1'b0;
		end
		// Bus writes in the data phase, clamped to range except inertia and presets
		if (st_ff.wr_pend) begin
			case (st_ff.addr)
				ssl_pkg::ADDR_MAX_SPEED: nxt_st.max_speed = clamp16(wv, ssl_pkg::MAX_SPEED_MAX);
				ssl_pkg::ADDR_KP: nxt_st.kp = clamp16(wv, ssl_pkg::KP_MAX);
				ssl_pkg::ADDR_KI: nxt_st.ki = clamp16(wv, ssl_pkg::KI_MAX);
				ssl_pkg::ADDR_KF: nxt_st.kf = clamp16(wv, ssl_pkg::KF_MAX);
				ssl_pkg::ADDR_TUNE: begin
					nxt_st.mode = ssl_pkg::ssl_tuning_e'(2'(clamp16(wv, ssl_pkg::TUNE_MAX)));
					if (clamp16(wv, ssl_pkg::TUNE_MAX) == 16'h0 && st_ff.mode != ssl_pkg::TUNE_MANUAL) begin
						nxt_st.kp = st_ff.auto_kp;
						nxt_st.ki = st_ff.auto_ki;
					end
					nxt_st.save_cnt = 40'h0;
				end
				ssl_pkg::ADDR_INERTIA: nxt_st.inertia = wv;
				ssl_pkg::ADDR_BW: nxt_st.bw = clamp16(wv, ssl_pkg::BW_MAX);
				ssl_pkg::ADDR_PRESET0: nxt_st.preset[0] = wv;
				ssl_pkg::ADDR_PRESET1: nxt_st.preset[1] = wv;
				ssl_pkg::ADDR_PRESET2: nxt_st.preset[2] = wv;
				default: nxt_st.addr = st_ff.addr;
			endcase
		end
		// Command selection
		nxt_st.speed_cmd = 16'h0;
		if (s_servo_on && !s_torque) begin
			case (s_sel)
				2'h0: nxt_st.speed_cmd = s_zref ? 16'h0 : sif.scaled;
				2'h1: nxt_st.speed_cmd = st_ff.preset[0];
				2'h2: nxt_st.speed_cmd = st_ff.preset[1];
				2'h3: nxt_st.speed_cmd = st_ff.preset[2];
				default: nxt_st.speed_cmd = 16'h0;
			endcase
		end
		nxt_st.speed_limit = s_torque ? sif.scaled : 16'h0;
		// Active gains and estimator enable
		nxt_st.est_en = st_ff.mode == ssl_pkg::TUNE_AUTO || (st_ff.mode == ssl_pkg::TUNE_SEMI && !st_ff.stable);
		if (st_ff.mode == ssl_pkg::TUNE_MANUAL) begin
			nxt_st.est_en = 1'b0;
			nxt_st.act_kp = st_ff.kp;
			nxt_st.act_ki = st_ff.ki;
		end else begin
			nxt_st.act_kp = st_ff.auto_kp;
			nxt_st.act_ki = st_ff.auto_ki;
		end
		nxt_st.act_kf = st_ff.kf;
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
			st_ff.max_speed <= ssl_pkg::MAX_SPEED_RST;
			st_ff.kp <= ssl_pkg::KP_RST;
			st_ff.ki <= ssl_pkg::KI_RST;
			st_ff.kf <= ssl_pkg::KF_RST;
			st_ff.mode <= ssl_pkg::TUNE_MANUAL;
			st_ff.inertia <= ssl_pkg::INERTIA_RST;
			st_ff.bw <= ssl_pkg::BW_RST;
			st_ff.act_kp <= ssl_pkg::KP_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign hreadyout = !st_ff.rd_wait;
	assign hresp = 1'b0;
	assign hrdata = st_ff.hrdata;
	assign speed_cmd = st_ff.speed_cmd;
	assign speed_limit = st_ff.speed_limit;
	assign proportional_gain = st_ff.act_kp;
	assign integral_gain = st_ff.act_ki;
	assign feedforward_gain = st_ff.act_kf;
	assign est_enable = st_ff.est_en;
	assign inertia_stable_status = st_ff.stable;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	property p_zero_ref;
		(s_servo_on && !s_torque && s_sel == 2'h0 && s_zref) |=> st_ff.speed_cmd == 16'h0;
	endproperty
	a_zero_ref: assert property (p_zero_ref) else $error("zero reference gave nonzero command");

	property p_analog_first;
		(s_servo_on && !s_torque && s_sel == 2'h0 && !s_zref) |=> st_ff.speed_cmd == $past(sif.scaled);
	endproperty
	a_analog_first: assert property (p_analog_first) else $error("first command not analog");

	property p_servo_off;
		!s_servo_on |=> st_ff.speed_cmd == 16'h0;
	endproperty
	a_servo_off: assert property (p_servo_off) else $error("command while servo off");

	property p_mode_range;
		st_ff.mode != 2'h3;
	endproperty
	a_mode_range: assert property (p_mode_range) else $error("tuning mode out of range");

	property p_manual;
		st_ff.mode == ssl_pkg::TUNE_MANUAL |=> !st_ff.est_en && st_ff.act_kp == $past(st_ff.kp);
	endproperty
	a_manual: assert property (p_manual) else $error("manual mode not using user gains");

	property p_to_manual;
		($past(st_ff.mode) != ssl_pkg::TUNE_MANUAL && st_ff.mode == ssl_pkg::TUNE_MANUAL)
			|-> st_ff.kp == $past(st_ff.auto_kp) && st_ff.ki == $past(st_ff.auto_ki);
	endproperty
	a_to_manual: assert property (p_to_manual) else $error("measured gains not loaded");

	property p_save;
		(st_ff.mode == ssl_pkg::TUNE_AUTO && save_due && !st_ff.wr_pend && !est_high)
			|=> st_ff.inertia == $past(s_est) && st_ff.save_cnt == 40'h0;
	endproperty
	a_save: assert property (p_save) else $error("periodic inertia save missed");

	property p_semi_stable;
		(st_ff.mode == ssl_pkg::TUNE_SEMI && !st_ff.stable && s_settled && !est_high && !st_ff.wr_pend)
			|=> st_ff.stable ##1 !st_ff.est_en;
	endproperty
	a_semi_stable: assert property (p_semi_stable) else $error("semi-auto did not settle");

	property p_high;
		(st_ff.mode != ssl_pkg::TUNE_MANUAL && est_high) |=> !st_ff.stable;
	endproperty
	a_high: assert property (p_high) else $error("stable kept on excessive inertia");

	property p_gain_range;
		st_ff.kp <= ssl_pkg::KP_MAX && st_ff.ki <= ssl_pkg::KI_MAX && st_ff.kf <= ssl_pkg::KF_MAX
			&& st_ff.max_speed <= ssl_pkg::MAX_SPEED_MAX;
	endproperty
	a_gain_range: assert property (p_gain_range) else $error("parameter beyond range");

	property p_read_wait;
		(bus_take && !hwrite) |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

	c_preset: cover property (s_servo_on && s_sel == 2'h2 ##1 st_ff.speed_cmd == st_ff.preset[1]);
	c_to_manual: cover property ($past(st_ff.mode) == ssl_pkg::TUNE_SEMI && st_ff.mode == ssl_pkg::TUNE_MANUAL);
	c_stable: cover property (!st_ff.stable ##1 st_ff.stable);
	c_save: cover property (st_ff.mode == ssl_pkg::TUNE_AUTO && save_due);

endmodule : ssl_speed_loop

// >>> ssl_estimator_model.sv
// Behavioural reference source and load inertia estimator.
// Assumes the bench sets targets; outputs move after hclk edges.
module ssl_estimator_model (
	input wire logic hclk,
	input wire logic [15:0] mv_set,
	input wire logic [15:0] inertia_set,
	input wire logic settle_req,
	output logic [15:0] ref_mv,
	output logic [15:0] est_inertia,
	output logic inertia_settled
);
	timeunit 1ns;
	timeprecision 1ps;

	// Start at the default load ratio
	initial begin
		ref_mv = 16'h0000;
		est_inertia = ssl_pkg::INERTIA_RST;
		inertia_settled = 1'b0;
	end

	// Estimate creeps one step per cycle toward the real load
	always @(posedge hclk) begin
		ref_mv <= mv_set;
		if (est_inertia < inertia_set) begin
			est_inertia <= est_inertia + 16'h0001;
		end else if (est_inertia > inertia_set) begin
			est_inertia <= est_inertia - 16'h0001;
		end
		inertia_settled <= settle_req && (est_inertia == inertia_set);
	end
endmodule : ssl_estimator_model

// >>> ssl_speed_loop_tb.sv
// Self-checking bench of the speed loop front end over AHB-Lite.
// Assumes the estimator model stands in for reference source and motor.
module ssl_speed_loop_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic servo_on = 1'b0;
	logic [1:0] sel = 2'h0;
	logic zref = 1'b0;
	logic tmode = 1'b0;
	logic [15:0] mv_set = 16'h0;
	logic [15:0] in_set = 16'h000a;
	logic settle_req = 1'b0;
	logic hreadyout, hresp, est_enable, stable, settled;
	logic [31:0] hrdata, q;
	logic [15:0] ref_mv, est_inertia, speed_cmd, speed_limit, kp, ki, kf, e;
	logic [15:0] mv_t [4] = '{16'h2710, 16'h1388, 16'h0d05, 16'hd8f0};
	logic [15:0] sp_t [4] = '{16'h0bb8, 16'h05dc, 16'h03e7, 16'hf448};
	logic [15:0] pr_t [3] = '{16'hfb2e, 16'h01f4, 16'h1b58};
	int error_cnt = 0;
	int samples_checked = 0;

	// Clock of 4 ns period
	always #2 hclk = ~hclk;

	ssl_estimator_model u_est (.hclk(hclk), .mv_set(mv_set), .inertia_set(in_set),
		.settle_req(settle_req), .ref_mv(ref_mv), .est_inertia(est_inertia), .inertia_settled(settled));

	ssl_speed_loop #(.SAVE_CYCLES(40'h32)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.servo_on(servo_on), .speed_select_inputs(sel), .zero_reference_speed_mode(zref),
		.torque_mode(tmode), .ref_mv(ref_mv), .est_inertia(est_inertia), .inertia_settled(settled),
		.speed_cmd(speed_cmd), .speed_limit(speed_limit), .proportional_gain(kp),
		.integral_gain(ki), .feedforward_gain(kf), .est_enable(est_enable),
		.inertia_stable_status(stable));

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// Look at hready mid-cycle, then pass the edge that samples it
	task automatic wait_rdy();
		int n;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(negedge hclk);
		end
		if (n >= 50) begin
			error_cnt++;
		end
		q = hrdata;
		@(posedge hclk);
	endtask : wait_rdy

	// One single word transfer: address phase, then data phase
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		wait_rdy();
	endtask : bus

	task automatic chk_reg(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		cmp(q, exp);
	endtask : chk_reg

	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		cmp({16'h0, got}, {16'h0, exp});
	endtask : chk_out

	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	// Hang guard
	initial begin
		#40us;
		error_cnt++;
		final_report();
	end

	// Main sequence
	initial begin
		cyc(8);
		hresetn <= 1'b1;
		cyc(1);
		chk_reg(ssl_pkg::ADDR_MAX_SPEED, 32'h0bb8);
		chk_reg(ssl_pkg::ADDR_KP, 32'h01f4);
		chk_reg(ssl_pkg::ADDR_KI, 32'h0);
		chk_reg(ssl_pkg::ADDR_KF, 32'h0);
		chk_reg(ssl_pkg::ADDR_TUNE, 32'h0);
		chk_reg(12'h3fc, 32'h0);
		chk_out(kp, 16'h01f4);
		chk_out({15'h0, est_enable}, 16'h0);
		chk_out({15'h0, hresp}, 16'h0);
		tdone("reset");
		bus(1'b1, ssl_pkg::ADDR_KP, 32'hffff);
		chk_reg(ssl_pkg::ADDR_KP, 32'h1fff);
		bus(1'b1, ssl_pkg::ADDR_KI, 32'h07d0);
		chk_reg(ssl_pkg::ADDR_KI, 32'h03ff);
		bus(1'b1, ssl_pkg::ADDR_KF, 32'h00c8);
		chk_reg(ssl_pkg::ADDR_KF, 32'h0064);
		bus(1'b1, ssl_pkg::ADDR_MAX_SPEED, 32'h4e20);
		chk_reg(ssl_pkg::ADDR_MAX_SPEED, 32'h2710);
		chk_out(kp, 16'h1fff);
		bus(1'b1, ssl_pkg::ADDR_MAX_SPEED, 32'h0bb8);
		tdone("clamp");
		servo_on <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			mv_set <= mv_t[i];
			cyc(8);
			chk_out(speed_cmd, sp_t[i]);
		end
		tmode <= 1'b1;
		cyc(8);
		chk_out(speed_limit, 16'hf448);
		chk_out(speed_cmd, 16'h0);
		tmode <= 1'b0;
		zref <= 1'b1;
		cyc(8);
		chk_out(speed_cmd, 16'h0);
		zref <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, ssl_pkg::ADDR_PRESET0 + 12'(4 * i), {16'h0, pr_t[i]});
		end
		for (int i = 0; i < 3; i++) begin
			sel <= 2'(i + 1);
			cyc(8);
			chk_out(speed_cmd, pr_t[i]);
		end
		chk_reg(ssl_pkg::ADDR_SPEED_RD, 32'h1b58);
		servo_on <= 1'b0;
		cyc(8);
		chk_out(speed_cmd, 16'h0);
		tdone("command");
		in_set <= 16'h001e;
		bus(1'b1, ssl_pkg::ADDR_INERTIA, 32'h001e);
		cyc(30);
		bus(1'b1, ssl_pkg::ADDR_TUNE, 32'h1);
		for (int b = 0; b < 11; b++) begin
			bus(1'b1, ssl_pkg::ADDR_BW, 32'(b));
			cyc(8);
			e = 16'(200 * ((b > 9 ? 9 : b) + 1));
			chk_out(kp, e);
			chk_out(ki, e / 4);
		end
		chk_out({15'h0, est_enable}, 16'h1);
		in_set <= 16'h0028;
		cyc(150);
		chk_reg(ssl_pkg::ADDR_INERTIA, 32'h0028);
		chk_out(kp, 16'h09c4);
		tdone("auto");
		bus(1'b1, ssl_pkg::ADDR_TUNE, 32'h0);
		cyc(4);
		chk_reg(ssl_pkg::ADDR_KP, 32'h09c4);
		chk_reg(ssl_pkg::ADDR_KI, 32'h0271);
		chk_out(kp, 16'h09c4);
		chk_out({15'h0, est_enable}, 16'h0);
		bus(1'b1, ssl_pkg::ADDR_KF, 32'h0032);
		cyc(4);
		chk_out(kf, 16'h0032);
		tdone("manual");
		bus(1'b1, ssl_pkg::ADDR_INERTIA, 32'h0014);
		in_set <= 16'h003c;
		settle_req <= 1'b1;
		bus(1'b1, ssl_pkg::ADDR_TUNE, 32'h3);
		chk_reg(ssl_pkg::ADDR_TUNE, 32'h2);
		cyc(60);
		chk_reg(ssl_pkg::ADDR_STATUS, 32'h1);
		chk_reg(ssl_pkg::ADDR_INERTIA, 32'h003c);
		chk_out({15'h0, stable}, 16'h1);
		in_set <= 16'h00fa;
		settle_req <= 1'b0;
		cyc(220);
		chk_reg(ssl_pkg::ADDR_STATUS, 32'h2);
		chk_out({15'h0, est_enable}, 16'h1);
		tdone("semi");
		final_report();
	end
endmodule : ssl_speed_loop_tb
